// ==== core/cabe_alu.sv ====
`timescale 1ns/1ns
module cabe_alu
  import cabe_pkg::*;
(
  input wire cabe_op_type op_i, // Operation
  input wire logic [7:0] a_i, // Rd
  input wire logic [7:0] b_i, // Rr or immediate
  input wire logic [15:0] word_i, // Register pair value
  input wire logic [7:0] flags_i, // Current flags
  output logic [15:0] res_o, // Result
  output logic [7:0] flags_o // Flags after the operation
);

  logic cin;
  logic a_sg;
  logic b_sg;
  logic [8:0] add_r;
  logic [8:0] sub_r;
  logic [16:0] w_add;
  logic [16:0] w_sub;
  logic signed [17:0] prod_s;
  logic [15:0] prod;
  logic [15:0] frac;
  logic [7:0] r8;

  // Shared adders; carry only for the with-carry forms
  assign cin = (op_i == OP_ADD_CARRY || op_i == OP_MINUS_WITH_BORROW ||
                op_i == OP_MINUS_CONST_BORROW || op_i == OP_COMPARE_WITH_CARRY) &&
               flags_i[FLAG_C];
  assign add_r = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin};
  assign sub_r = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin};
  assign w_add = {1'b0, word_i} + {11'h000, b_i[5:0]};
  assign w_sub = {1'b0, word_i} - {11'h000, b_i[5:0]};

  // One 9x9 signed multiplier covers all signedness mixes
  assign a_sg = op_i inside {OP_SIGNED_PRODUCT, OP_MIXED_PRODUCT,
                             OP_FRAC_SIGNED_PRODUCT, OP_FRAC_MIXED_PRODUCT};
  assign b_sg = op_i inside {OP_SIGNED_PRODUCT, OP_FRAC_SIGNED_PRODUCT};
  assign prod_s = $signed({a_sg & a_i[7], a_i}) * $signed({b_sg & b_i[7], b_i});
  assign prod = prod_s[15:0];
  assign frac = {prod[14:0], 1'b0};

  // Result and flag update per operation
  always_comb
  begin
    res_o = 16'h0000;
    flags_o = flags_i;
    r8 = BYTE_ZERO;
    case (op_i)
      OP_ADD, OP_ADD_CARRY:
      begin
        r8 = add_r[7:0];
        res_o = {8'h00, r8};
        flags_o[FLAG_H] = (a_i[3] & b_i[3]) | (b_i[3] & ~r8[3]) | (~r8[3] & a_i[3]); // RULE_07
        flags_o[FLAG_V] = (a_i[7] & b_i[7] & ~r8[7]) | (~a_i[7] & ~b_i[7] & r8[7]);
        flags_o[FLAG_C] = add_r[8];
        flags_o[FLAG_N] = r8[7];
        flags_o[FLAG_Z] = (r8 == BYTE_ZERO);
      end
      OP_SUB, OP_MINUS_CONST, OP_MINUS_WITH_BORROW, OP_MINUS_CONST_BORROW,
      OP_COMPARE_REGS, OP_COMPARE_WITH_CARRY, OP_COMPARE_IMM:
      begin
        r8 = sub_r[7:0];
        res_o = {8'h00, r8};
        flags_o[FLAG_H] = (~a_i[3] & b_i[3]) | (b_i[3] & r8[3]) | (r8[3] & ~a_i[3]); // RULE_17
        flags_o[FLAG_V] = (a_i[7] & ~b_i[7] & ~r8[7]) | (~a_i[7] & b_i[7] & r8[7]);
        flags_o[FLAG_C] = sub_r[8];
        flags_o[FLAG_N] = r8[7];
        // Carry forms keep zero only if it was already set, for multi-byte chains
        flags_o[FLAG_Z] = (r8 == BYTE_ZERO) && (!cin_form(op_i) || flags_i[FLAG_Z]);
      end
      OP_WORD_PLUS_IMM, OP_WORD_MINUS_IMM:
      begin
        res_o = (op_i == OP_WORD_PLUS_IMM) ? w_add[15:0] : w_sub[15:0]; // RULE_08
        flags_o[FLAG_V] = (op_i == OP_WORD_PLUS_IMM) ? (~word_i[15] & res_o[15])
                                                      : (word_i[15] & ~res_o[15]);
        flags_o[FLAG_C] = (op_i == OP_WORD_PLUS_IMM) ? (word_i[15] & ~res_o[15])
                                                      : (~word_i[15] & res_o[15]);
        flags_o[FLAG_N] = res_o[15];
        flags_o[FLAG_S] = res_o[15] ^ flags_o[FLAG_V];
        flags_o[FLAG_Z] = (res_o == 16'h0000);
      end
      OP_AND, OP_BITAND_CONST, OP_OR, OP_BITOR_CONST, OP_BITXOR_REGS,
      OP_SET_MASK_BITS, OP_CLEAR_MASK_BITS, OP_ZERO_MINUS_TEST:
      begin
        if (op_i == OP_AND || op_i == OP_BITAND_CONST)
          r8 = a_i & b_i; // RULE_09
        else if (op_i == OP_OR || op_i == OP_BITOR_CONST || op_i == OP_SET_MASK_BITS)
          r8 = a_i | b_i; // RULE_10
        else if (op_i == OP_CLEAR_MASK_BITS)
          r8 = a_i & (MASK_ALL - b_i); // RULE_10
        else if (op_i == OP_ZERO_MINUS_TEST)
          r8 = a_i & a_i; // RULE_11
        else
          r8 = a_i ^ b_i;
        res_o = {8'h00, r8};
        flags_o[FLAG_V] = 1'b0;
        flags_o[FLAG_N] = r8[7];
        flags_o[FLAG_Z] = (r8 == BYTE_ZERO);
      end
      OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_PRODUCT:
      begin
        res_o = prod; // RULE_12
        flags_o[FLAG_C] = prod[15];
        flags_o[FLAG_Z] = (prod == 16'h0000);
      end
      OP_FRAC_UNSIGNED_PRODUCT, OP_FRAC_SIGNED_PRODUCT, OP_FRAC_MIXED_PRODUCT:
      begin
        res_o = frac; // RULE_13
        flags_o[FLAG_C] = prod[15];
        flags_o[FLAG_Z] = (frac == 16'h0000);
      end
      default:
      begin
        res_o = 16'h0000;
      end
    endcase
  end

  function automatic logic cin_form(input cabe_op_type op);
    cin_form = (op == OP_MINUS_WITH_BORROW || op == OP_MINUS_CONST_BORROW ||
                op == OP_COMPARE_WITH_CARRY);
  endfunction

endmodule

// ==== core/cabe_exec.sv ====
`timescale 1ns/1ns
// Functional notes
// RULE_01: Software zeroes reserved bits; reserved I/O is never written.
// RULE_02: Bit set, clear and skips act only on I/O 0x00..0x1F.
// RULE_03: Bit set and clear touch only the addressed bit.
// RULE_04: Some status flags clear on a written one.
// RULE_05: Port I/O 0x00..0x3F; data space adds 0x20.
// RULE_06: Extended I/O 0x60..0xFF by data-space access only.
// RULE_07: Register add and subtract forms: 1 cycle, flags Z C N V H.
// RULE_08: Word add or subtract immediate: 2 cycles, flags Z C N V S.
// RULE_09: AND, OR, XOR: 1 cycle, flags Z N V.
// RULE_10: Set-bits ORs constant; clear-bits ANDs 0xFF minus constant.
// RULE_11: Zero-or-minus test ANDs register with itself: 1 cycle, Z N V.
// RULE_12: Multiplies write product to pair one:zero, 2 cycles, flags Z C.
// RULE_13: Fractional multiplies shift product left one, 2 cycles.
// RULE_14: Relative jump PC+k+1, indirect Z: 2 cycles; direct jump 3.
// RULE_15: Relative and indirect calls 3 cycles, direct 4; indirect targets Z.
// RULE_16: Skips advance PC by 2 or 3, taking 1, 2 or 3 cycles.
// RULE_17: Compares subtract without storing: 1 cycle, flags Z N V C H.
// RULE_18: Flag branches load PC+k+1 if taken; 1 cycle, 2 if taken.
// RULE_19: Signed ge taken when N xor V is 0, lt when 1.
// RULE_20: Unsigned ge on carry clear, lower on carry set.
// RULE_21: Branches on I, T, V and H flags, set or clear.
// RULE_22: I/O bit set or clear: 2 cycles, no flag change.
// RULE_23: Skips advance 3 over a two-word instruction.
module cabe_exec
  import cabe_pkg::*;
(
  input wire logic core_clk_i, // Core clock
  input wire logic rst_i, // Synchronous reset
  input wire logic req_valid_i, // Request present
  input wire cabe_req_type req_i, // Decoded request
  output logic ready_o, // Request taken when high with valid
  output logic done_o, // Result valid pulse
  output cabe_res_type result_o, // Result bundle
  output logic [15:0] pc_o, // Program counter
  output logic [7:0] flags_o, // Flag register
  input wire logic flag_wr_i, // External flag write
  input wire logic [7:0] flag_wdata_i, // External flag value
  output logic io_rd_o, // I/O read strobe
  output logic [7:0] io_raddr_o, // I/O read address, data space
  input wire logic [7:0] io_rdata_i, // I/O read data, same cycle
  input wire logic [7:0] event_i, // Peripheral events
  output logic [7:0] event_flags_o // Write-one-to-clear event flags
);

  typedef enum {ST_IDLE, ST_BUSY} cabe_state_type;

  localparam logic [7:0] EVT_DS = IO_DS_OFFSET + {2'b00, EVT_PORT};
  localparam logic [7:0] BIT_DS_MAX = IO_DS_OFFSET + {2'b00, IO_BIT_PORT_MAX};

  cabe_state_type state_q, state_d;
  logic [2:0] cnt_q, cnt_d;
  cabe_res_type pend_q, pend_d, out_q, out_d;
  logic [7:0] pflags_q, pflags_d, flags_q, flags_d;
  logic [15:0] ppc_q, ppc_d, pc_q, pc_d;
  logic done_q, done_d;
  logic [7:0] evt_q, evt_d;
  logic accept;
  logic [15:0] alu_res;
  logic [7:0] alu_flags;
  logic [7:0] ds_addr;
  logic io_hit;
  logic [7:0] rdata;
  logic [7:0] bit_mask;
  logic cond;
  logic [2:0] cyc;
  cabe_res_type calc;
  logic [15:0] npc;
  logic [15:0] rel_pc;
  logic [15:0] skip_pc;
  logic [2:0] skip_cyc;
  logic [7:0] evt_clr;

  cabe_alu u_alu (
    .op_i(req_i.op),
    .a_i(req_i.a),
    .b_i(req_i.b),
    .word_i(req_i.word),
    .flags_i(flags_q),
    .res_o(alu_res),
    .flags_o(alu_flags)
  );

  assign accept = req_valid_i && (state_q == ST_IDLE);
  assign ready_o = (state_q == ST_IDLE);
  assign rel_pc = pc_q + req_i.k + PC_STEP;
  assign skip_pc = pc_q + (req_i.next_two_word ? PC_THREE : PC_TWO); // RULE_23
  assign skip_cyc = req_i.next_two_word ? CYC_SKIP_TWO : CYC_SKIP_ONE; // RULE_16
  assign bit_mask = MASK_BIT0 << req_i.sel;

  // I/O address: port forms add the offset, data-space forms use it as is
  always_comb
  begin
    ds_addr = req_i.addr;
    io_hit = 1'b0;
    if (req_i.op inside {OP_SET_IO_BIT, OP_CLEAR_IO_BIT, OP_SKIP_IO_BIT_CLEAR,
                         OP_SKIP_IO_BIT_SET})
    begin
      ds_addr = IO_DS_OFFSET + {2'b00, req_i.addr[5:0]}; // RULE_05
      io_hit = (req_i.addr[5:0] <= IO_BIT_PORT_MAX); // RULE_02
    end
    else if (req_i.op == OP_PORT_IN || req_i.op == OP_PORT_OUT)
    begin
      // Six address bits keep port forms out of the extended region
      ds_addr = IO_DS_OFFSET + {2'b00, req_i.addr[5:0]}; // RULE_05 RULE_06
      io_hit = 1'b1;
    end
    else if (req_i.op == OP_LOAD_DIRECT || req_i.op == OP_WRITE_DIRECT)
    begin
      io_hit = (req_i.addr >= IO_DS_OFFSET); // RULE_06
    end
  end

  // The event flag register answers reads itself; all else comes from outside
  assign io_raddr_o = ds_addr;
  assign io_rd_o = accept && io_hit && !(req_i.op inside {OP_PORT_OUT, OP_WRITE_DIRECT});
  assign rdata = (ds_addr == EVT_DS) ? evt_q : io_rdata_i;

  // Per-operation result, next PC and cycle count
  always_comb
  begin
    calc = '0;
    cyc = CYC_ONE;
    npc = pc_q + PC_STEP;
    cond = 1'b0;
    case (req_i.op)
      OP_ADD, OP_ADD_CARRY, OP_SUB, OP_MINUS_CONST, OP_MINUS_WITH_BORROW,
      OP_MINUS_CONST_BORROW, OP_AND, OP_BITAND_CONST, OP_OR, OP_BITOR_CONST,
      OP_BITXOR_REGS, OP_SET_MASK_BITS, OP_CLEAR_MASK_BITS, OP_ZERO_MINUS_TEST:
      begin
        calc.wr_byte = 1'b1; // RULE_07 RULE_09 RULE_11
        calc.data = alu_res;
      end
      OP_WORD_PLUS_IMM, OP_WORD_MINUS_IMM:
      begin
        calc.wr_word = 1'b1;
        calc.data = alu_res;
        cyc = CYC_WORD; // RULE_08
      end
      OP_UNSIGNED_PRODUCT, OP_SIGNED_PRODUCT, OP_MIXED_PRODUCT,
      OP_FRAC_UNSIGNED_PRODUCT, OP_FRAC_SIGNED_PRODUCT, OP_FRAC_MIXED_PRODUCT:
      begin
        calc.wr_prod = 1'b1;
        calc.data = alu_res;
        cyc = CYC_MUL; // RULE_12 RULE_13
      end
      OP_RELATIVE_JUMP:
      begin
        npc = rel_pc;
        cyc = CYC_RELATIVE_JUMP; // RULE_14
      end
      OP_INDIRECT_JUMP:
      begin
        npc = req_i.word; // RULE_14
        cyc = CYC_INDIRECT_JUMP;
      end
      OP_DIRECT_JUMP:
      begin
        npc = req_i.k;
        cyc = CYC_JMP; // RULE_14
      end
      OP_RELATIVE_CALL, OP_INDIRECT_CALL:
      begin
        calc.push = 1'b1;
        calc.push_addr = pc_q + PC_STEP;
        npc = (req_i.op == OP_RELATIVE_CALL) ? rel_pc : req_i.word; // RULE_15
        cyc = (req_i.op == OP_RELATIVE_CALL) ? CYC_RELATIVE_CALL : CYC_INDIRECT_CALL;
      end
      OP_DIRECT_CALL:
      begin
        calc.push = 1'b1;
        calc.push_addr = pc_q + PC_TWO;
        npc = req_i.k;
        cyc = CYC_CALL; // RULE_15
      end
      OP_EQUAL_SKIP, OP_SKIP_REG_BIT_CLEAR, OP_SKIP_REG_BIT_SET,
      OP_SKIP_IO_BIT_CLEAR, OP_SKIP_IO_BIT_SET:
      begin
        if (req_i.op == OP_EQUAL_SKIP)
          cond = (req_i.a == req_i.b);
        else if (req_i.op == OP_SKIP_REG_BIT_CLEAR)
          cond = !req_i.a[req_i.sel];
        else if (req_i.op == OP_SKIP_REG_BIT_SET)
          cond = req_i.a[req_i.sel];
        else if (req_i.op == OP_SKIP_IO_BIT_CLEAR)
          cond = io_hit && !rdata[req_i.sel]; // RULE_02
        else
          cond = io_hit && rdata[req_i.sel];
        if (cond)
        begin
          npc = skip_pc; // RULE_16
          cyc = skip_cyc;
        end
      end
      OP_BRANCH_FLAG_SET, OP_BRANCH_FLAG_CLEAR, OP_BRANCH_SIGNED_GE, OP_BRANCH_SIGNED_LT:
      begin
        // Any flag by select covers carry, zero, I, T, V and H aliases
        if (req_i.op == OP_BRANCH_FLAG_SET)
          cond = flags_q[req_i.sel]; // RULE_20 RULE_21
        else if (req_i.op == OP_BRANCH_FLAG_CLEAR)
          cond = !flags_q[req_i.sel]; // RULE_20 RULE_21
        else if (req_i.op == OP_BRANCH_SIGNED_GE)
          cond = !(flags_q[FLAG_N] ^ flags_q[FLAG_V]); // RULE_19
        else
          cond = flags_q[FLAG_N] ^ flags_q[FLAG_V]; // RULE_19
        if (cond)
        begin
          npc = rel_pc; // RULE_18
          cyc = CYC_BR_TAKEN;
        end
      end
      OP_SET_IO_BIT, OP_CLEAR_IO_BIT:
      begin
        // Masked write: only the addressed bit reaches the peripheral
        calc.io_we = io_hit; // RULE_02
        calc.io_addr = ds_addr;
        calc.io_mask = bit_mask; // RULE_03
        calc.io_data = (req_i.op == OP_SET_IO_BIT) ? bit_mask : BYTE_ZERO;
        cyc = CYC_BIT_IO; // RULE_22
      end
      OP_PORT_IN, OP_LOAD_DIRECT:
      begin
        calc.wr_byte = 1'b1;
        calc.data = {8'h00, io_hit ? rdata : BYTE_ZERO};
        cyc = (req_i.op == OP_PORT_IN) ? CYC_ONE : CYC_LDST;
      end
      OP_PORT_OUT, OP_WRITE_DIRECT:
      begin
        calc.io_we = io_hit;
        calc.io_addr = ds_addr;
        calc.io_mask = MASK_ALL;
        calc.io_data = req_i.a;
        cyc = (req_i.op == OP_PORT_OUT) ? CYC_ONE : CYC_LDST;
      end
      default:
      begin
        cyc = CYC_ONE;
      end
    endcase
  end

  // Sequencer: single-cycle work commits at once, longer work waits out its count
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    pend_d = pend_q;
    pflags_d = pflags_q;
    ppc_d = ppc_q;
    out_d = '0;
    done_d = 1'b0;
    flags_d = flag_wr_i ? flag_wdata_i : flags_q;
    pc_d = pc_q;
    case (state_q)
      ST_IDLE:
      begin
        if (accept && cyc == CYC_ONE)
        begin
          out_d = calc;
          done_d = 1'b1;
          flags_d = alu_flags;
          pc_d = npc;
        end
        else if (accept)
        begin
          state_d = ST_BUSY;
          cnt_d = cyc - CYC_ONE;
          pend_d = calc;
          pflags_d = alu_flags; // RULE_22
          ppc_d = npc;
        end
      end
      ST_BUSY:
      begin
        cnt_d = cnt_q - CYC_ONE;
        if (cnt_q == CYC_ONE)
        begin
          state_d = ST_IDLE;
          out_d = pend_q;
          done_d = 1'b1;
          flags_d = pflags_q;
          pc_d = ppc_q;
        end
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_IDLE;
      cnt_q <= 3'h0;
      pend_q <= '0;
      out_q <= '0;
      pflags_q <= FLAGS_RESET;
      ppc_q <= PC_RESET;
      flags_q <= FLAGS_RESET;
      pc_q <= PC_RESET;
      done_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      pend_q <= pend_d;
      out_q <= out_d;
      pflags_q <= pflags_d;
      ppc_q <= ppc_d;
      flags_q <= flags_d;
      pc_q <= pc_d;
      done_q <= done_d;
    end
  end

  // Event flags: a one written clears, a new event in the same cycle wins
  assign evt_clr = (out_q.io_we && out_q.io_addr == EVT_DS) ? (out_q.io_data & out_q.io_mask)
                                                          : BYTE_ZERO;
  always_comb
  begin
    evt_d = (evt_q & ~evt_clr) | event_i; // RULE_04
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      evt_q <= BYTE_ZERO;
    else
      evt_q <= evt_d;
  end

  assign done_o = done_q;
  assign result_o = out_q;
  assign pc_o = pc_q;
  assign flags_o = flags_q;
  assign event_flags_o = evt_q;

  // Checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  sequence two_quiet_s;
    !done_o ##1 !done_o;
  endsequence

  bit_range_a: assert property (result_o.io_we && result_o.io_mask != MASK_ALL
      |-> result_o.io_addr <= BIT_DS_MAX) // RULE_02
    else $error("bit write outside low I/O range");
  bit_onehot_a: assert property (result_o.io_we && result_o.io_mask != MASK_ALL
      |-> $onehot(result_o.io_mask)) // RULE_03
    else $error("bit write touches more than one bit");
  evt_clear_a: assert property (evt_clr != BYTE_ZERO && event_i == BYTE_ZERO
      |=> (event_flags_o & $past(evt_clr)) == BYTE_ZERO) // RULE_04
    else $error("written one did not clear event flag");
  port_map_a: assert property (accept && req_i.op == OP_PORT_IN
      |-> io_raddr_o == IO_DS_OFFSET + {2'b00, req_i.addr[5:0]} && io_raddr_o < EXT_IO_LO) // RULE_05
    else $error("port address mapped wrongly");
  add_time_a: assert property (accept && req_i.op == OP_ADD
      |=> done_o && result_o.wr_byte) // RULE_07
    else $error("register add not done in one cycle");
  word_time_a: assert property (accept && req_i.op == OP_WORD_PLUS_IMM
      |=> !done_o ##1 (done_o && result_o.wr_word)) // RULE_08
    else $error("word add not done in two cycles");
  logic_flag_a: assert property (accept && req_i.op == OP_BITXOR_REGS
      |=> !flags_o[FLAG_V] && flags_o[FLAG_C] == $past(flags_o[FLAG_C])) // RULE_09
    else $error("logic op flags wrong");
  frac_prod_a: assert property (accept && req_i.op == OP_FRAC_UNSIGNED_PRODUCT
      |=> !done_o ##1 (done_o && result_o.wr_prod && !result_o.data[0])) // RULE_13
    else $error("fractional product not shifted in two cycles");
  call_time_a: assert property (accept && req_i.op == OP_DIRECT_CALL
      |=> two_quiet_s ##1 !done_o ##1 (done_o && pc_o == $past(req_i.k, 4))) // RULE_15
    else $error("direct call not four cycles");
  branch_ge_a: assert property (accept && req_i.op == OP_BRANCH_SIGNED_GE
      && flags_o[FLAG_N] == flags_o[FLAG_V]
      |=> !done_o ##1 (done_o && pc_o == $past(rel_pc, 2))) // RULE_19
    else $error("signed ge branch not taken correctly");
  bit_flags_a: assert property (accept && req_i.op == OP_SET_IO_BIT && !flag_wr_i
      |=> !done_o ##1 (done_o && flags_o == $past(flags_o, 2))) // RULE_22
    else $error("bit set changed flags or timing");

endmodule

// ==== core/cabe_pkg.sv ====
package cabe_pkg;

  // Operations carried out by the execute block
  typedef enum logic [5:0] {
    OP_NOP,
    OP_ADD,
    OP_ADD_CARRY,
    OP_SUB,
    OP_MINUS_CONST,
    OP_MINUS_WITH_BORROW,
    OP_MINUS_CONST_BORROW,
    OP_WORD_PLUS_IMM,
    OP_WORD_MINUS_IMM,
    OP_AND,
    OP_BITAND_CONST,
    OP_OR,
    OP_BITOR_CONST,
    OP_BITXOR_REGS,
    OP_SET_MASK_BITS,
    OP_CLEAR_MASK_BITS,
    OP_ZERO_MINUS_TEST,
    OP_UNSIGNED_PRODUCT,
    OP_SIGNED_PRODUCT,
    OP_MIXED_PRODUCT,
    OP_FRAC_UNSIGNED_PRODUCT,
    OP_FRAC_SIGNED_PRODUCT,
    OP_FRAC_MIXED_PRODUCT,
    OP_COMPARE_REGS,
    OP_COMPARE_WITH_CARRY,
    OP_COMPARE_IMM,
    OP_RELATIVE_JUMP,
    OP_INDIRECT_JUMP,
    OP_DIRECT_JUMP,
    OP_RELATIVE_CALL,
    OP_INDIRECT_CALL,
    OP_DIRECT_CALL,
    OP_EQUAL_SKIP,
    OP_SKIP_REG_BIT_CLEAR,
    OP_SKIP_REG_BIT_SET,
    OP_SKIP_IO_BIT_CLEAR,
    OP_SKIP_IO_BIT_SET,
    OP_BRANCH_FLAG_SET,
    OP_BRANCH_FLAG_CLEAR,
    OP_BRANCH_SIGNED_GE,
    OP_BRANCH_SIGNED_LT,
    OP_SET_IO_BIT,
    OP_CLEAR_IO_BIT,
    OP_PORT_IN,
    OP_PORT_OUT,
    OP_LOAD_DIRECT,
    OP_WRITE_DIRECT
  } cabe_op_type;

  // Decoded request: a is Rd, b is Rr or the immediate
  typedef struct packed {
    cabe_op_type op;
    logic [7:0] a;
    logic [7:0] b;
    logic [15:0] word;
    logic [15:0] k;
    logic [2:0] sel;
    logic [7:0] addr;
    logic next_two_word;
  } cabe_req_type;

  // Committed result, valid for the one cycle done is high
  typedef struct packed {
    logic wr_byte;
    logic wr_word;
    logic wr_prod;
    logic [15:0] data;
    logic push;
    logic [15:0] push_addr;
    logic io_we;
    logic [7:0] io_addr;
    logic [7:0] io_data;
    logic [7:0] io_mask;
  } cabe_res_type;

  // Flag positions in the flag register
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;

  // I/O map
  localparam logic [7:0] IO_DS_OFFSET = 8'h20;
  localparam logic [5:0] IO_BIT_PORT_MAX = 6'h1F;
  localparam logic [7:0] EXT_IO_LO = 8'h60;
  localparam logic [5:0] EVT_PORT = 6'h16;
  localparam logic [7:0] MASK_ALL = 8'hFF;
  localparam logic [7:0] MASK_BIT0 = 8'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // Cycle counts
  localparam logic [2:0] CYC_ONE = 3'h1;
  localparam logic [2:0] CYC_WORD = 3'h2;
  localparam logic [2:0] CYC_MUL = 3'h2;
  localparam logic [2:0] CYC_RELATIVE_JUMP = 3'h2;
  localparam logic [2:0] CYC_INDIRECT_JUMP = 3'h2;
  localparam logic [2:0] CYC_JMP = 3'h3;
  localparam logic [2:0] CYC_RELATIVE_CALL = 3'h3;
  localparam logic [2:0] CYC_INDIRECT_CALL = 3'h3;
  localparam logic [2:0] CYC_CALL = 3'h4;
  localparam logic [2:0] CYC_BIT_IO = 3'h2;
  localparam logic [2:0] CYC_LDST = 3'h2;
  localparam logic [2:0] CYC_BR_TAKEN = 3'h2;
  localparam logic [2:0] CYC_SKIP_ONE = 3'h2;
  localparam logic [2:0] CYC_SKIP_TWO = 3'h3;

  // Program counter steps, in 16-bit words
  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [15:0] PC_TWO = 16'h0002;
  localparam logic [15:0] PC_THREE = 16'h0003;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

endpackage

// ==== verification/cabe_io_model.sv ====
`timescale 1ns/1ns
module cabe_io_model
  import cabe_pkg::*;
(
  input wire logic clk_i, // Core clock
  input wire logic [7:0] raddr_i, // Data-space address
  output logic [7:0] rdata_o, // Same-cycle read data
  input wire logic done_i, // Commit pulse
  input wire cabe_res_type res_i // Committed write
);
  logic [7:0] mem_q [256];
  // Preset to the inverted address, so a stale byte never passes
  initial foreach (mem_q[i]) mem_q[i] = 8'(~i);
  assign rdata_o = mem_q[raddr_i];
  // Only masked bits change, and only on commit
  always @(posedge clk_i)
  begin
    if (done_i && res_i.io_we)
    begin
      mem_q[res_i.io_addr] <= (mem_q[res_i.io_addr] & ~res_i.io_mask)
        | (res_i.io_data & res_i.io_mask);
    end
  end
endmodule

// ==== verification/test_cpu_alu_branch_execute.sv ====
`timescale 1ns/1ns
module test_cpu_alu_branch_execute;
  import cabe_pkg::*;
  typedef struct {cabe_op_type op; logic [7:0] a, b; logic [15:0] w; logic [7:0] fi;
    int cyc; logic [2:0] wr; logic [15:0] d; logic [7:0] fo;} cabe_row_type;
  logic clk = 0, rst = 1, vld = 0, fw = 0, rdy, done;
  logic [7:0] fwd = 8'h00, ev = 8'h00, rd, raddr, evf, fl, pat = 8'hA5;
  logic [15:0] pc, p0;
  cabe_req_type rq = '0;
  cabe_res_type res;
  cabe_row_type r;
  int miscompares = 0, n_compared = 0, n;
  localparam logic [7:0] Z8 = 8'h00;
  localparam logic [15:0] Z16 = 16'h0000;
  // Operation, operands, flags in, cycles, writes, data, flags out
  cabe_row_type rows [14] = '{
    '{OP_ADD, 8'h80, 8'h80, Z16, Z8, 1, 3'h4, Z16, 8'h0B},
    '{OP_ADD_CARRY, 8'h0F, Z8, Z16, 8'h01, 1, 3'h4, 16'h0010, 8'h20},
    '{OP_SUB, Z8, 8'h01, Z16, 8'h10, 1, 3'h4, 16'h00FF, 8'h35},
    '{OP_MINUS_WITH_BORROW, 8'h05, 8'h05, Z16, 8'h03, 1, 3'h4, 16'h00FF, 8'h25},
    '{OP_AND, 8'hF0, 8'h8F, Z16, 8'h09, 1, 3'h4, 16'h0080, 8'h05},
    '{OP_BITXOR_REGS, 8'h55, 8'h55, Z16, Z8, 1, 3'h4, Z16, 8'h02},
    '{OP_CLEAR_MASK_BITS, 8'hFF, 8'h0F, Z16, Z8, 1, 3'h4, 16'h00F0, 8'h04},
    '{OP_ZERO_MINUS_TEST, Z8, Z8, Z16, 8'h08, 1, 3'h4, Z16, 8'h02},
    '{OP_UNSIGNED_PRODUCT, 8'hFF, 8'hFF, Z16, Z8, 2, 3'h1, 16'hFE01, 8'h01},
    '{OP_SIGNED_PRODUCT, 8'hFF, 8'h02, Z16, Z8, 2, 3'h1, 16'hFFFE, 8'h01},
    '{OP_FRAC_UNSIGNED_PRODUCT, 8'h80, 8'h80, Z16, Z8, 2, 3'h1, 16'h8000, Z8},
    '{OP_COMPARE_IMM, 8'h10, 8'h20, Z16, 8'h02, 1, 3'h0, Z16, 8'h05},
    '{OP_WORD_PLUS_IMM, Z8, 8'h01, 16'hFFFF, Z8, 2, 3'h2, Z16, 8'h03},
    '{OP_WORD_MINUS_IMM, Z8, 8'h01, 16'h8000, Z8, 2, 3'h2, 16'h7FFF, 8'h18}};
  always #2 clk = ~clk;
  cabe_exec u_dut (.core_clk_i(clk), .rst_i(rst), .req_valid_i(vld), .req_i(rq),
    .ready_o(rdy), .done_o(done), .result_o(res), .pc_o(pc), .flags_o(fl),
    .flag_wr_i(fw), .flag_wdata_i(fwd), .io_rd_o(), .io_raddr_o(raddr),
    .io_rdata_i(rd), .event_i(ev), .event_flags_o(evf));
  cabe_io_model u_mem (.clk_i(clk), .raddr_i(raddr), .rdata_o(rd), .done_i(done),
    .res_i(res));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Load flags, then one request; the wait for done is bounded
  task automatic go(cabe_op_type o, logic [7:0] a, b, logic [15:0] w, k, logic [2:0] s,
    logic [7:0] ad, logic t, logic [7:0] fi);
    @(posedge clk) #1 fw = 1;
    fwd = fi;
    @(posedge clk) #1 fw = 0;
    rq = '{o, a, b, w, k, s, ad, t};
    vld = 1;
    p0 = pc;
    @(posedge clk) #1 vld = 0;
    n = 1;
    while (done !== 1'b1 && n < 9)
    begin
      @(posedge clk) #1 n++;
    end
    if (done !== 1'b1)
    begin
      miscompares++;
      wrap_up();
    end
  endtask
  task automatic cp(input int c, input logic [15:0] p);
    chk("cycles", 16'(c), 16'(n));
    chk("pc", p, pc);
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    #1 rst = 0;
    chk("reset", 16'h8000, {rdy, done, 6'h00, fl});
    chk("reset pc", Z16, pc | {Z8, evf});
    foreach (rows[i])
    begin
      r = rows[i];
      go(r.op, r.a, r.b, r.w, Z16, 3'h0, Z8, 1'b0, r.fi);
      chk("cycles", 16'(r.cyc), 16'(n));
      chk("flags", {8'h00, r.fo}, {8'h00, fl});
      chk("writes", {13'h0000, r.wr}, {13'h0000, res.wr_byte, res.wr_word, res.wr_prod});
      if (r.wr != 3'h0)
        chk("data", r.d, r.wr[2] ? {8'h00, res.data[7:0]} : res.data);
    end
    // Every flag index, taken on set bits of the pattern only
    for (int s = 0; s < 8; s++)
    begin
      go(OP_BRANCH_FLAG_SET, Z8, Z8, Z16, 16'h0005, 3'(s), Z8, 1'b0, pat);
      cp(pat[s] ? 2 : 1, p0 + (pat[s] ? 16'h0006 : 16'h0001));
    end
    go(OP_BRANCH_FLAG_CLEAR, Z8, Z8, Z16, 16'h0005, 3'h0, Z8, 1'b0, Z8);
    cp(2, p0 + 16'h0006);
    go(OP_BRANCH_SIGNED_GE, Z8, Z8, Z16, 16'h0005, 3'h0, Z8, 1'b0, 8'h0C);
    cp(2, p0 + 16'h0006);
    go(OP_BRANCH_SIGNED_LT, Z8, Z8, Z16, 16'h0005, 3'h0, Z8, 1'b0, 8'h0C);
    cp(1, p0 + 16'h0001);
    go(OP_RELATIVE_JUMP, Z8, Z8, Z16, 16'hFFFE, 3'h0, Z8, 1'b0, Z8);
    cp(2, p0 - 16'h0001);
    go(OP_INDIRECT_JUMP, Z8, Z8, 16'h1234, Z16, 3'h0, Z8, 1'b0, Z8);
    cp(2, 16'h1234);
    go(OP_DIRECT_JUMP, Z8, Z8, Z16, 16'h0456, 3'h0, Z8, 1'b0, Z8);
    cp(3, 16'h0456);
    go(OP_RELATIVE_CALL, Z8, Z8, Z16, 16'h0003, 3'h0, Z8, 1'b0, Z8);
    cp(3, p0 + 16'h0004);
    chk("push", p0 + 16'h0001, res.push_addr);
    go(OP_INDIRECT_CALL, Z8, Z8, 16'h0200, Z16, 3'h0, Z8, 1'b0, Z8);
    cp(3, 16'h0200);
    go(OP_DIRECT_CALL, Z8, Z8, Z16, 16'h0300, 3'h0, Z8, 1'b0, Z8);
    cp(4, 16'h0300);
    chk("push", p0 + 16'h0002, res.push_addr);
    go(OP_EQUAL_SKIP, 8'h07, 8'h07, Z16, Z16, 3'h0, Z8, 1'b1, Z8);
    cp(3, p0 + 16'h0003);
    go(OP_EQUAL_SKIP, 8'h07, 8'h06, Z16, Z16, 3'h0, Z8, 1'b1, Z8);
    cp(1, p0 + 16'h0001);
    go(OP_SKIP_REG_BIT_CLEAR, 8'hFE, Z8, Z16, Z16, 3'h0, Z8, 1'b0, Z8);
    cp(2, p0 + 16'h0002);
    go(OP_SKIP_IO_BIT_SET, Z8, Z8, Z16, Z16, 3'h1, 8'h05, 1'b0, Z8);
    cp(2, p0 + 16'h0002);
    go(OP_SKIP_IO_BIT_SET, Z8, Z8, Z16, Z16, 3'h1, 8'h21, 1'b0, Z8);
    cp(1, p0 + 16'h0001);
    go(OP_SET_IO_BIT, Z8, Z8, Z16, Z16, 3'h0, 8'h05, 1'b0, 8'h3F);
    chk("bit op", 16'h023F, {n[7:0], fl});
    chk("io write", 16'h2501, {res.io_addr, res.io_mask});
    go(OP_PORT_IN, Z8, Z8, Z16, Z16, 3'h0, 8'h05, 1'b0, Z8);
    chk("port in", 16'h00DB, {Z8, res.data[7:0]});
    go(OP_LOAD_DIRECT, Z8, Z8, Z16, Z16, 3'h0, 8'h25, 1'b0, Z8);
    chk("load", 16'h00DB, {Z8, res.data[7:0]});
    go(OP_LOAD_DIRECT, Z8, Z8, Z16, Z16, 3'h0, 8'h60, 1'b0, Z8);
    chk("load ext", 16'h009F, {Z8, res.data[7:0]});
    // Event flag: a cleared bit spares it, a set bit clears it
    @(posedge clk) #1 ev = 8'h08;
    @(posedge clk) #1 ev = Z8;
    go(OP_CLEAR_IO_BIT, Z8, Z8, Z16, Z16, 3'h3, 8'h16, 1'b0, Z8);
    @(posedge clk) #1 chk("events", 16'h0008, {Z8, evf});
    go(OP_SET_IO_BIT, Z8, Z8, Z16, Z16, 3'h3, 8'h16, 1'b0, Z8);
    @(posedge clk) #1 chk("events", Z16, {Z8, evf});
    rst = 1;
    @(posedge clk) #1 rst = 0;
    chk("rerun", Z16, pc);
    wrap_up();
  end
endmodule
